// *** rtl/tdc_readout_pkg.sv ***
package tdc_readout_pkg;
  // link addresses
  localparam logic [7:0] ADDR_CH1 = 8'h15;
  localparam logic [7:0] ADDR_CH2 = 8'h1b;
  localparam logic [7:0] ADDR_STAT4 = 8'h22;
  localparam logic [7:0] ADDR_STAT3 = 8'h20;
  localparam logic [7:0] ADDR_REARM = 8'h30;
  // result encoding
  localparam logic [23:0] MISSING_TIME = 24'hffffff;
  localparam logic [1:0] FMT_TWO_BYTE = 2'h1;
  localparam logic [1:0] FMT_TIME_ONLY = 2'h2;
  localparam logic [2:0] SLOTS = 3'h4;
  localparam logic SSN_REARM_EN = 1'b0;
  // host register map
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  // control fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_NB_LSB = 8;
  localparam int CTRL_REARM_BIT = 16;
  localparam int CTRL_GO_BIT = 17;
  localparam int CTRL_HOLD_BIT = 18;
  localparam int CTRL_DATA_ONLY_BIT = 19;
  // interrupt bits
  localparam int EV_DONE = 0;
  localparam int EV_DEV_IRQ = 1;
  localparam int EV_REFUSED = 2;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // timing
  localparam int PCLK_MHZ = 100;
  localparam int SCLK_HALF_NS = 80;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS * PCLK_MHZ / 1000);
  localparam int REARM_PIN_NS = 40;
  localparam logic [2:0] REARM_PIN_CYC = 3'((REARM_PIN_NS * PCLK_MHZ + 999) / 1000);
  typedef enum logic [2:0] {SRC_NONE, SRC_CH1, SRC_CH2, SRC_ST3, SRC_ST4} src_t;
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} host_state_t;
endpackage : tdc_readout_pkg

// *** rtl/tdc_link_if.sv ***
`timescale 1ns/1ps
interface tdc_link_if;
  logic sclk;
  logic ssn;
  logic mosi;
  logic miso;
  logic dev_irq;
  logic rearm_pin;
  modport device (input sclk, input ssn, input mosi, input rearm_pin, output miso, output dev_irq);
  modport host (output sclk, output ssn, output mosi, output rearm_pin, input miso, input dev_irq);
endinterface : tdc_link_if

// *** rtl/tdc_readout_device.sv ***
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Function
// - missing stop slot reads as all ones
// - address 0x15 serves successive channel one pulses
// - address 0x1b serves successive channel two pulses
// - separate read pointers for both channels
// - four byte status word at 0x22
// - host may read three byte status at 0x20, the low three bytes of the word
// - re-arm by pin or command only
// - incremental 0x15 alternates channel one, two
// - combined mode steers first input alternately
// - combined two-byte mode streams eight words
// - format 2 gives three byte words
// - format 1 drops least significant byte
// - access mode selects single or incremental
module tdc_readout_device
  import tdc_readout_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // link
  tdc_link_if.device lnk,
  // measurement results
  input wire logic stop_pulse,
  input wire logic stop_channel,
  input wire logic [23:0] stop_time,
  input wire logic meas_done,
  // configuration
  input wire logic [1:0] readout_format,
  input wire logic access_sequencing_mode,
  input wire logic combined_mode,
  // re-arm indication
  output logic rearm_measurement
);
  import tdc_readout_pkg::*;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] ssn_s;
    logic [2:0] mosi_s;
    logic [2:0] rpin_s;
    logic [2:0] bit_cnt;
    logic data_ph;
    logic [7:0] addr;
    src_t src;
    logic alt;
    logic [31:0] word;
    logic [2:0] left;
    logic [7:0] sh;
    logic miso;
    logic [2:0] rd1;
    logic [2:0] rd2;
    logic [2:0] cnt1;
    logic [2:0] cnt2;
    logic [3:0][23:0] slot1;
    logic [3:0][23:0] slot2;
    logic steer;
    logic done;
    logic rearm;
  } dev_t;

  dev_t q;
  dev_t n;

  logic rise;
  logic fall;
  logic sel;
  logic to_ch2;
  logic take;
  logic cmd_rearm;
  logic [7:0] a;
  logic [23:0] flight_time_word;
  logic [31:0] w;
  logic [2:0] nb;
  logic [7:0] b;
  logic [31:0] stat;

  always_comb begin
    n = q;
    rise = 1'b0;
    fall = 1'b0;
    sel = 1'b0;
    to_ch2 = 1'b0;
    take = 1'b0;
    cmd_rearm = 1'b0;
    a = 8'h00;
    flight_time_word = MISSING_TIME;
    w = 32'hffffffff;
    nb = 3'h4;
    b = 8'hff;
    stat = {15'h0000, q.done, 5'h00, q.cnt1, 5'h00, q.cnt2};
    if (ce) begin
      n.rearm = 1'b0;
      n.sclk_s = {q.sclk_s[1:0], lnk.sclk};
      n.ssn_s = {q.ssn_s[1:0], lnk.ssn};
      n.mosi_s = {q.mosi_s[1:0], lnk.mosi};
      n.rpin_s = {q.rpin_s[1:0], lnk.rearm_pin};
      rise = q.sclk_s[1] & ~q.sclk_s[2];
      fall = ~q.sclk_s[1] & q.sclk_s[2];
      sel = ~q.ssn_s[1];
      // result capture
      take = stop_pulse & ~q.done & ~(combined_mode & stop_channel);
      to_ch2 = combined_mode ? q.steer : stop_channel;
      if (take && combined_mode) begin
        n.steer = ~q.steer;
      end
      if (take && !to_ch2 && q.cnt1 < SLOTS) begin
        n.slot1[q.cnt1[1:0]] = stop_time;
        n.cnt1 = q.cnt1 + 3'h1;
      end
      if (take && to_ch2 && q.cnt2 < SLOTS) begin
        n.slot2[q.cnt2[1:0]] = stop_time;
        n.cnt2 = q.cnt2 + 3'h1;
      end
      // link
      if (!sel) begin
        n.bit_cnt = 3'h0;
        n.data_ph = 1'b0;
        n.src = SRC_NONE;
        n.left = 3'h0;
        n.miso = 1'b0;
      end else begin
        if (rise) begin
          n.bit_cnt = q.bit_cnt + 3'h1;
          a = {q.addr[6:0], q.mosi_s[1]};
          if (!q.data_ph) begin
            n.addr = a;
          end
          if (!q.data_ph && q.bit_cnt == 3'h7) begin
            n.data_ph = 1'b1;
            n.alt = access_sequencing_mode;
            case (a)
              ADDR_CH1: n.src = SRC_CH1;
              ADDR_CH2: n.src = SRC_CH2;
              ADDR_STAT3: n.src = SRC_ST3;
              ADDR_STAT4: n.src = SRC_ST4;
              ADDR_REARM: cmd_rearm = 1'b1;
              default: n.src = SRC_NONE;
            endcase
            if (a == ADDR_CH2) begin
              n.alt = 1'b0;
            end
          end
        end
        if (fall && q.data_ph && q.bit_cnt == 3'h0) begin
          if (q.left == 3'h0) begin
            case (q.src)
              SRC_CH1: begin
                if (q.rd1 < SLOTS) begin
                  flight_time_word = q.slot1[q.rd1[1:0]];
                  n.rd1 = q.rd1 + 3'h1;
                end
                if (!access_sequencing_mode) begin
                  n.src = SRC_NONE;
                end else if (q.alt) begin
                  n.src = SRC_CH2;
                end
              end
              SRC_CH2: begin
                if (q.rd2 < SLOTS) begin
                  flight_time_word = q.slot2[q.rd2[1:0]];
                  n.rd2 = q.rd2 + 3'h1;
                end
                if (!access_sequencing_mode) begin
                  n.src = SRC_NONE;
                end else if (q.alt) begin
                  n.src = SRC_CH1;
                end
              end
              default: n.src = SRC_NONE;
            endcase
            case (q.src)
              SRC_CH1, SRC_CH2: begin
                if (readout_format == FMT_TWO_BYTE) begin
                  w = {flight_time_word[23:8], 16'h0000};
                  nb = 3'h2;
                end else begin
                  w = {flight_time_word, 8'h00};
                  nb = 3'h3;
                end
              end
              SRC_ST3: begin
                w = {stat[23:0], 8'h00};
                nb = 3'h3;
                n.src = SRC_NONE;
              end
              SRC_ST4: begin
                w = stat;
                nb = 3'h4;
                n.src = SRC_NONE;
              end
              default: begin
                w = 32'hffffffff;
                nb = 3'h4;
              end
            endcase
          end else begin
            w = q.word;
            nb = q.left;
          end
          b = w[31:24];
          n.word = {w[23:0], 8'h00};
          n.left = nb - 3'h1;
          n.miso = b[7];
          n.sh = {b[6:0], 1'b0};
        end else if (fall && q.data_ph) begin
          n.miso = q.sh[7];
          n.sh = {q.sh[6:0], 1'b0};
        end
      end
      // re-arm: pin edge or command, never select edge
      if ((q.rpin_s[1] & ~q.rpin_s[2]) | cmd_rearm | (SSN_REARM_EN & ~sel)) begin
        n.done = 1'b0;
        n.cnt1 = 3'h0;
        n.cnt2 = 3'h0;
        n.rd1 = 3'h0;
        n.rd2 = 3'h0;
        n.steer = 1'b0;
        n.rearm = 1'b1;
        for (int i = 0; i < 4; i++) begin
          n.slot1[i] = MISSING_TIME;
          n.slot2[i] = MISSING_TIME;
        end
      end
      // completion wins over a re-arm in the same cycle
      if (meas_done) begin
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ssn_s <= 3'h7;
      q.src <= SRC_NONE;
      q.slot1 <= {4{MISSING_TIME}};
      q.slot2 <= {4{MISSING_TIME}};
    end else begin
      q <= n;
    end
  end

  assign lnk.miso = q.miso;
  assign lnk.dev_irq = q.done;
  assign rearm_measurement = q.rearm;
endmodule : tdc_readout_device

// *** rtl/tdc_readout_host.sv ***
`timescale 1ns/1ps
module tdc_readout_host
  import tdc_readout_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tdc_readout_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // link
  tdc_link_if.host lnk
);
  import tdc_readout_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [3:0] div;
    logic sclk;
    logic ssn;
    logic mosi;
    logic hold;
    logic [7:0] tx;
    logic [5:0] bits;
    logic [31:0] rx;
    logic [2:0] miso_s;
    logic [2:0] irq_s;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic [2:0] rp_cnt;
    logic rp;
    logic irq;
  } host_t;

  host_t q;
  host_t n;
  logic wr;
  logic rd_clr;
  logic mapped;
  logic [2:0] ev;
  logic [7:0] ca;
  logic [5:0] nbits;
  logic donly;

  always_comb begin
    mapped = paddr == OFS_CTRL || paddr == OFS_STATUS || paddr == OFS_RXDATA ||
             paddr == OFS_INT_STAT || paddr == OFS_INT_MASK;
    wr = psel & penable & pwrite;
    rd_clr = psel & penable & ~pwrite & (paddr == OFS_INT_STAT);
    ca = pwdata[CTRL_ADDR_LSB +: 8];
    donly = pwdata[CTRL_DATA_ONLY_BIT];
    nbits = (donly ? 6'd0 : 6'd8) + {pwdata[CTRL_NB_LSB +: 3], 3'h0};
    ev = 3'h0;
    n = q;
    if (ce) begin
      n.miso_s = {q.miso_s[1:0], lnk.miso};
      n.irq_s = {q.irq_s[1:0], lnk.dev_irq};
      ev[EV_DEV_IRQ] = q.irq_s[1] & ~q.irq_s[2];
      if (psel && !penable) begin
        case (paddr)
          OFS_STATUS: n.rdata = {28'h0000000, q.irq_s[1], ~q.ssn, q.st != H_IDLE, q.rp};
          OFS_RXDATA: n.rdata = q.rx;
          OFS_INT_STAT: n.rdata = {29'h0000000, q.stat};
          OFS_INT_MASK: n.rdata = {29'h0000000, q.mask};
          default: n.rdata = 32'h00000000;
        endcase
      end
      if (wr && paddr == OFS_INT_MASK) begin
        n.mask = pwdata[2:0];
      end
      if (wr && paddr == OFS_CTRL && pwdata[CTRL_REARM_BIT]) begin
        n.rp_cnt = REARM_PIN_CYC;
      end
      if (wr && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT]) begin
        if (q.st != H_IDLE || nbits == 6'd0 ||
            (!donly && (ca == ADDR_CH1 || ca == ADDR_CH2) && !q.irq_s[1])) begin
          ev[EV_REFUSED] = 1'b1;
        end else begin
          n.st = H_RUN;
          n.tx = donly ? 8'h00 : ca;
          n.mosi = donly ? 1'b0 : ca[7];
          n.bits = nbits;
          n.rx = 32'h00000000;
          n.ssn = 1'b0;
          n.sclk = 1'b0;
          n.div = 4'h0;
          n.hold = pwdata[CTRL_HOLD_BIT];
        end
      end
      n.rp = q.rp_cnt != 3'h0;
      if (q.rp_cnt != 3'h0) begin
        n.rp_cnt = q.rp_cnt - 3'h1;
      end
      case (q.st)
        H_RUN: begin
          n.div = q.div + 4'h1;
          if (q.div == SCLK_HALF_CYC - 4'h1) begin
            n.div = 4'h0;
            n.sclk = ~q.sclk;
            if (q.sclk) begin
              n.rx = {q.rx[30:0], q.miso_s[1]};
              n.tx = {q.tx[6:0], 1'b0};
              n.mosi = q.tx[6];
              n.bits = q.bits - 6'd1;
              if (q.bits == 6'd1) begin
                ev[EV_DONE] = 1'b1;
                n.ssn = ~q.hold;
                n.st = q.hold ? H_IDLE : H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          n.div = q.div + 4'h1;
          if (q.div == SCLK_HALF_CYC - 4'h1) begin
            n.div = 4'h0;
            n.st = H_IDLE;
          end
        end
        H_IDLE: n.div = 4'h0;
        default: n.st = H_IDLE;
      endcase
      // clear only what the read reported, so later events survive
      n.stat = (q.stat & ~(rd_clr ? q.rdata[2:0] : 3'h0)) | ev;
      n.irq = |(n.stat & n.mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= H_IDLE;
      q.ssn <= 1'b1;
      q.mask <= MASK_RESET;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq = q.irq;
  assign lnk.sclk = q.sclk;
  assign lnk.ssn = q.ssn;
  assign lnk.mosi = q.mosi;
  assign lnk.rearm_pin = q.rp;
endmodule : tdc_readout_host

// *** bench/tdc_readout_checker.sv ***
`timescale 1ns/1ps
module tdc_readout_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic sclk,
  input wire logic ssn,
  input wire logic mosi,
  input wire logic miso,
  input wire logic dev_irq,
  input wire logic rearm_pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_sclk_idle_low: assert property (ssn |-> !sclk)
    else $error("sclk high while deselected");
  a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high phase not 8 cycles");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low phase short");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_miso_steady: assert property (!ssn && sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk high");
  a_frame_gap: assert property ($rose(ssn) |-> ssn [*8])
    else $error("select gap short");
  a_frame_start: assert property ($fell(ssn) |-> !sclk [*4])
    else $error("sclk rose too soon after select");
  a_rearm_width: assert property ($rose(rearm_pin) |-> rearm_pin [*4] ##1 !rearm_pin)
    else $error("rearm pulse not 4 cycles");
  c_frame: cover property ($fell(ssn));
  c_irq: cover property ($rose(dev_irq));
  c_rearm: cover property ($rose(rearm_pin));
endmodule : tdc_readout_checker

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tdc_readout_pkg::*;
  localparam logic [31:0] HLD = 32'h1 << CTRL_HOLD_BIT;
  localparam logic [31:0] DON = 32'h1 << CTRL_DATA_ONLY_BIT;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sp = 1'b0, sc = 1'b0, md = 1'b0, acc = 1'b0, comb = 1'b0;
  logic pready, pslverr, irq, e, rm;
  logic [1:0] fmt = FMT_TWO_BYTE;
  logic [7:0] paddr = 8'h00;
  logic [23:0] st = 24'h000000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int nrm = 0;
  tdc_link_if lnk ();
  tdc_readout_device tdc_readout_device_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .lnk(lnk.device),
    .stop_pulse(sp), .stop_channel(sc), .stop_time(st), .meas_done(md), .readout_format(fmt),
    .access_sequencing_mode(acc), .combined_mode(comb), .rearm_measurement(rm));
  tdc_readout_host tdc_readout_host_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lnk(lnk.host));
  tdc_readout_checker tdc_readout_checker_i (.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk), .ssn(lnk.ssn),
    .mosi(lnk.mosi), .miso(lnk.miso), .dev_irq(lnk.dev_irq), .rearm_pin(lnk.rearm_pin));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic test_done;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rm === 1'b1)
      nrm <= nrm + 1;
    if (cyc == 60000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic xfer(input logic [7:0] a, input int nb, input logic [31:0] fl);
    int n;
    n = 0;
    apb(1'b1, OFS_CTRL, fl | (32'(nb) << CTRL_NB_LSB) | 32'(a) | (32'h1 << CTRL_GO_BIT));
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (r[1] !== 1'b0 && n < 400);
    apb(1'b0, OFS_RXDATA, 32'h0);
  endtask : xfer
  task automatic wst(input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (r[3] !== v && n < 100);
    chk("dev_irq", {31'h0, r[3]}, {31'h0, v});
  endtask : wst
  task automatic hit(input logic d, input logic ch, input logic [23:0] tv);
    @(posedge pclk);
    sp <= ~d;
    md <= d;
    sc <= ch;
    st <= tv;
    @(posedge pclk);
    sp <= 1'b0;
    md <= 1'b0;
  endtask : hit
  task automatic rearm(input logic pin);
    if (pin)
      apb(1'b1, OFS_CTRL, 32'h1 << CTRL_REARM_BIT);
    else
      xfer(ADDR_REARM, 0, 32'h0);
    wst(1'b0);
  endtask : rearm
  task automatic burst(input int n, input logic [127:0] v);
    for (int i = 0; i < n; i++) begin
      xfer(i == 0 ? ADDR_CH1 : 8'h00, 4, (i < n - 1 ? HLD : 32'h0) | (i > 0 ? DON : 32'h0));
      chk("burst", r, v[127 - 32 * i -: 32]);
    end
  endtask : burst
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_INT_MASK, 32'h0);
    chk("int_mask", r, 32'(MASK_RESET));
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {e, r[30:0]}, 32'h80000000);
    xfer(ADDR_CH1, 2, 32'h0);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk("refused", r, 32'h4);
    xfer(8'h40, 2, 32'h0);
    chk("unknown_addr", r, 32'h0000ffff);
    apb(1'b1, OFS_INT_MASK, 32'h7);
    hit(1'b0, 1'b0, 24'h123456);
    hit(1'b0, 1'b1, 24'h654321);
    hit(1'b1, 1'b0, 24'h0);
    wst(1'b1);
    chk("irq", {31'h0, irq}, 32'h1);
    xfer(ADDR_STAT3, 3, 32'h0);
    chk("stat3", r, 32'h00010101);
    xfer(ADDR_CH1, 2, 32'h0);
    chk("ch1_w0", r, 32'h1234);
    xfer(ADDR_CH2, 2, 32'h0);
    chk("ch2_w0", r, 32'h6543);
    xfer(ADDR_CH1, 2, 32'h0);
    chk("ch1_w1", r, 32'hffff);
    xfer(ADDR_CH2, 2, 32'h0);
    chk("ch2_w1", r, 32'hffff);
    xfer(ADDR_STAT4, 4, 32'h0);
    chk("stat_a", r, 32'h00010101);
    apb(1'b0, OFS_INT_STAT, 32'h0);
    chk("int_stat", r, 32'h3);
    rearm(1'b1);
    fmt <= FMT_TIME_ONLY;
    acc <= 1'b1;
    hit(1'b0, 1'b0, 24'ha00001);
    hit(1'b0, 1'b1, 24'hb00001);
    hit(1'b0, 1'b0, 24'ha00002);
    hit(1'b1, 1'b0, 24'h0);
    wst(1'b1);
    burst(3, {24'ha00001, 24'hb00001, 24'ha00002, 24'hffffff, 32'h0});
    xfer(ADDR_STAT4, 4, 32'h0);
    chk("stat_b", r, 32'h00010201);
    rearm(1'b0);
    comb <= 1'b1;
    fmt <= FMT_TWO_BYTE;
    for (int i = 0; i < 8; i++)
      hit(1'b0, 1'b0, {8'(i + 1), 8'h3c, 8'h77});
    hit(1'b0, 1'b1, 24'hdddddd);
    hit(1'b1, 1'b0, 24'h0);
    wst(1'b1);
    burst(4, 128'h013c023c033c043c053c063c073c083c);
    xfer(ADDR_STAT4, 4, 32'h0);
    chk("stat_c", r, 32'h00010404);
    rearm(1'b1);
    chk("rearm_count", 32'(nrm), 32'h3);
    test_done();
  end
endmodule : testbench
